// ---- satl_link.sv ----
/*
 Synchronous coupling of four primary word recognizers to one
 auxiliary 8-bit recognizer, with trigger commands and storage.
 Assumes inputs synchronous to CLK_I; the state clock arrives as a
 one-cycle enable; the program sequencer issues trigger commands.
*/
// Operation
// - Aux recognizer extends primary words, linked per field
// - Four primary recognizers share one aux recognizer
// - Pattern change applies to all referencing recognizers
// - Aux triggered only by its trigger command
// - Qualification stores only qualified samples
// - Asynchronous samples ignore qualification entirely
// - Aux command starts delay, then completes storage
// - Sync mode chosen only by aux config
// - Linked aux true triggers primary acquisition
// - Link one needs aux true, zero false
// - No acquisition without matching trigger command
// - Aux channels compared to ones, zeros, don't-cares
// - Aux recognizer sampled by level at edge
// - Aux event stretched true over state period
`default_nettype none
module satl_link
  import satl_pkg::*;
(
  input  wire logic                     CLK_I,
  input  wire logic                     RST_I,
  input  wire logic                     STATE_EN_I,
  input  wire logic                     ARM_I,
  input  wire logic                     SYNC_MODE_I,
  input  wire logic                     QUALIFY_I,
  input  wire logic [MAIN_W-1:0]        MAIN_DATA_I,
  input  wire logic [AUX_W-1:0]         AUX_DATA_I,
  input  wire logic                     EXTERNAL_TRIGGER_INPUT_I,
  input  wire logic [NUM_WR*MAIN_W-1:0] WR_VAL_I,
  input  wire logic [NUM_WR*MAIN_W-1:0] WR_CARE_I,
  input  wire logic [NUM_WR*2-1:0]      WR_EXT_I,
  input  wire logic [NUM_WR*2-1:0]      WR_LINK_I,
  input  wire logic [NUM_WR-1:0]        WR_USED_MAIN_I,
  input  wire logic [NUM_WR-1:0]        WR_USED_AUX_I,
  input  wire logic [AUX_W-1:0]         AUX_VAL_I,
  input  wire logic [AUX_W-1:0]         AUX_CARE_I,
  input  wire logic                     CMD_TRIG_MAIN_I,
  input  wire logic                     CMD_TRIG_AUX_I,
  input  wire logic [CNT_W-1:0]         MAIN_DELAY_I,
  input  wire logic [CNT_W-1:0]         AUX_DELAY_I,
  input  wire logic [ADDR_W-1:0]        MAIN_RD_ADDR_I,
  input  wire logic [ADDR_W-1:0]        AUX_RD_ADDR_I,
  output logic      [MAIN_W-1:0]        MAIN_RD_DATA_O,
  output logic      [AUX_W-1:0]         AUX_RD_DATA_O,
  output logic      [NUM_WR-1:0]        WR_EVENT_O,
  output logic                          AUX_WR_O,
  output logic                          MAIN_TRIG_O,
  output logic                          AUX_TRIG_O,
  output logic                          MAIN_DONE_O,
  output logic                          AUX_DONE_O,
  output logic      [ADDR_W-1:0]        MAIN_COUNT_O,
  output logic      [ADDR_W-1:0]        AUX_COUNT_O
);
  logic              aux_now;
  logic              aux_stretch_r;
  logic              aux_ev;
  logic [NUM_WR-1:0] wr_ev;
  logic              main_fire;
  logic              aux_fire;
  logic              aux_store_ok;
  logic [MAIN_W-1:0] main_rd;
  logic [AUX_W-1:0]  aux_rd;
  logic [ADDR_W-1:0] main_cnt;
  logic [ADDR_W-1:0] aux_cnt;
  logic              main_run;
  logic              aux_run;
  logic              main_done;
  logic              aux_done;

  // =======================================================
  // Aux recognizer, single shared copy
  assign aux_now = satl_match8(AUX_DATA_I, AUX_VAL_I, AUX_CARE_I);

  // Catches any true moment within the state period
  always_ff @(posedge CLK_I)
  begin
    if (RST_I || STATE_EN_I) aux_stretch_r <= 1'b0;
    else if (aux_now) aux_stretch_r <= 1'b1;
  end

  // Level result at the state edge, stretched by the period history
  assign aux_ev = aux_now || aux_stretch_r;

  // =======================================================
  // Primary word recognizers
  always_comb
  begin
    for (int i = 0; i < NUM_WR; i++)
    begin
      wr_ev[i] = ((MAIN_DATA_I ^ WR_VAL_I[i*MAIN_W +: MAIN_W]) & WR_CARE_I[i*MAIN_W +: MAIN_W])
                 == '0
                 && satl_link_ok(WR_EXT_I[i*2 +: 2], EXTERNAL_TRIGGER_INPUT_I)
                 && satl_link_ok(WR_LINK_I[i*2 +: 2], aux_ev);
    end
  end

  // Sync mode alone decides whether the aux section follows qualification
  assign main_fire    = STATE_EN_I && CMD_TRIG_MAIN_I && |(wr_ev & WR_USED_MAIN_I);
  assign aux_fire     = STATE_EN_I && CMD_TRIG_AUX_I && |(wr_ev & WR_USED_AUX_I);
  assign aux_store_ok = SYNC_MODE_I ? QUALIFY_I : 1'b1;

  // =======================================================
  // Acquisition sections
  satl_acq #(.DW(MAIN_W)) u_main (
    .clk_i      (CLK_I),
    .rst_i      (RST_I),
    .st_en_i    (STATE_EN_I),
    .start_i    (ARM_I),
    .trig_i     (main_fire),
    .store_ok_i (QUALIFY_I),
    .delay_i    (MAIN_DELAY_I),
    .data_i     (MAIN_DATA_I),
    .rd_addr_i  (MAIN_RD_ADDR_I),
    .rd_data_o  (main_rd),
    .wr_addr_o  (main_cnt),
    .trig_loc_o (),
    .running_o  (main_run),
    .done_o     (main_done)
  );

  satl_acq #(.DW(AUX_W)) u_aux (
    .clk_i      (CLK_I),
    .rst_i      (RST_I),
    .st_en_i    (STATE_EN_I),
    .start_i    (ARM_I),
    .trig_i     (aux_fire),
    .store_ok_i (aux_store_ok),
    .delay_i    (AUX_DELAY_I),
    .data_i     (AUX_DATA_I),
    .rd_addr_i  (AUX_RD_ADDR_I),
    .rd_data_o  (aux_rd),
    .wr_addr_o  (aux_cnt),
    .trig_loc_o (),
    .running_o  (aux_run),
    .done_o     (aux_done)
  );

  // =======================================================
  // Registered outputs
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      WR_EVENT_O   <= '0;
      AUX_WR_O     <= 1'b0;
      MAIN_TRIG_O  <= 1'b0;
      AUX_TRIG_O   <= 1'b0;
      MAIN_DONE_O  <= 1'b0;
      AUX_DONE_O   <= 1'b0;
      MAIN_COUNT_O <= ADDR_RST;
      AUX_COUNT_O  <= ADDR_RST;
      MAIN_RD_DATA_O <= '0;
      AUX_RD_DATA_O  <= '0;
    end
    else
    begin
      if (STATE_EN_I)
      begin
        WR_EVENT_O <= wr_ev;
        AUX_WR_O   <= aux_ev;
      end
      MAIN_TRIG_O    <= main_fire && main_run;
      AUX_TRIG_O     <= aux_fire && aux_run;
      MAIN_DONE_O    <= main_done;
      AUX_DONE_O     <= aux_done;
      MAIN_COUNT_O   <= main_cnt;
      AUX_COUNT_O    <= aux_cnt;
      MAIN_RD_DATA_O <= main_rd;
      AUX_RD_DATA_O  <= aux_rd;
    end
  end

  // =======================================================
  // Checks
  sequence aux_cmd_s;
    STATE_EN_I && CMD_TRIG_AUX_I && |(wr_ev & WR_USED_AUX_I);
  endsequence

  aux_no_cmd_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    !CMD_TRIG_AUX_I |=> !AUX_TRIG_O) else $error("Aux trigger without command");
  main_no_cmd_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    !CMD_TRIG_MAIN_I |=> !MAIN_TRIG_O) else $error("Main trigger without command");
  aux_cmd_trig_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    aux_cmd_s ##0 aux_run |=> AUX_TRIG_O) else $error("Aux command lost");
  link_one_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (WR_LINK_I[1:0] == LINK_TRUE) && !aux_ev |-> !wr_ev[0]) else $error("Link one broken");
  link_zero_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (WR_LINK_I[1:0] == LINK_FALSE) && aux_ev |-> !wr_ev[0]) else $error("Link zero broken");
  stretch_hold_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    aux_now && !STATE_EN_I |=> aux_ev) else $error("Aux event not stretched");
  aux_pattern_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (AUX_CARE_I == '0) |-> aux_ev) else $error("All don't-care not matching");
  main_qual_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    !QUALIFY_I && !ARM_I |=> $stable(main_cnt)) else $error("Unqualified main sample stored");
  async_store_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    !SYNC_MODE_I && STATE_EN_I && aux_run && !ARM_I |=> aux_cnt == $past(aux_cnt) + 8'h01)
    else $error("Async sample skipped");
  share_aux_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    WR_LINK_I == 8'h55 && wr_ev != 4'h0 |-> aux_ev) else $error("Shared aux mismatch");
endmodule : satl_link
`default_nettype wire

// ---- satl_pkg.sv ----
/*
 Constants and types for the synchronous auxiliary trigger link.
 Assumes one system clock with a one-cycle state clock enable.
*/
`default_nettype none
package satl_pkg;
  localparam int unsigned AUX_W      = 8;
  localparam int unsigned MAIN_W     = 16;
  localparam int unsigned NUM_WR     = 4;
  localparam int unsigned CNT_W      = 16;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned MEM_DEPTH  = 256;
  localparam logic [CNT_W-1:0]  DLY_RST  = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
  // Link field encodings
  localparam logic [1:0] LINK_FALSE = 2'h0;
  localparam logic [1:0] LINK_TRUE  = 2'h1;
  localparam logic [1:0] LINK_DC    = 2'h2;

  typedef enum logic [1:0] {SATL_IDLE, SATL_PRE, SATL_POST, SATL_DONE} satl_acq_e;

  // Pattern match with don't-care mask: care bit set means compare
  function automatic logic satl_match8(input logic [AUX_W-1:0] d,
                                       input logic [AUX_W-1:0] val,
                                       input logic [AUX_W-1:0] care);
    satl_match8 = ((d ^ val) & care) == '0;
  endfunction : satl_match8

  function automatic logic satl_link_ok(input logic [1:0] link, input logic aux);
    case (link)
      LINK_TRUE:  satl_link_ok = aux;
      LINK_FALSE: satl_link_ok = !aux;
      default:    satl_link_ok = 1'b1;
    endcase
  endfunction : satl_link_ok
endpackage : satl_pkg
`default_nettype wire

// ---- satl_acq.sv ----
/*
 One acquisition section: delay counter and sample memory.
 Assumes a one-cycle trigger pulse and a state clock enable.
*/
`default_nettype none
module satl_acq
  import satl_pkg::*;
#(
  parameter int unsigned DW = 8
)(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              st_en_i,
  input  wire logic              start_i,
  input  wire logic              trig_i,
  input  wire logic              store_ok_i,
  input  wire logic [CNT_W-1:0]  delay_i,
  input  wire logic [DW-1:0]     data_i,
  input  wire logic [ADDR_W-1:0] rd_addr_i,
  output logic      [DW-1:0]     rd_data_o,
  output logic      [ADDR_W-1:0] wr_addr_o,
  output logic      [ADDR_W-1:0] trig_loc_o,
  output logic                   running_o,
  output logic                   done_o
);
  satl_acq_e          state_r;
  logic [CNT_W-1:0]   cnt_r;
  logic [DW-1:0]      mem [MEM_DEPTH];
  logic               wr;

  assign wr        = st_en_i && store_ok_i && (state_r == SATL_PRE || state_r == SATL_POST);
  // Only a section still waiting may take a trigger; later ones are refused
  assign running_o = (state_r == SATL_PRE);
  assign done_o    = (state_r == SATL_DONE);

  // =======================================================
  // Sequencing
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r    <= SATL_IDLE;
      cnt_r      <= DLY_RST;
      trig_loc_o <= ADDR_RST;
    end
    else if (start_i)
    begin
      // Re-arm restarts from any state, a run in progress included
      state_r <= SATL_PRE;
      cnt_r   <= DLY_RST;
    end
    else
    begin
      case (state_r)
        SATL_IDLE: state_r <= SATL_IDLE;
        SATL_PRE:
          if (trig_i)
          begin
            state_r    <= SATL_POST;
            cnt_r      <= DLY_RST;
            trig_loc_o <= wr_addr_o;
          end
        SATL_POST:
          if (wr)
          begin
            // Counts stored samples only, so delay is in qualified words
            if (cnt_r == delay_i) state_r <= SATL_DONE;
            else cnt_r <= cnt_r + 16'h0001;
          end
        SATL_DONE: state_r <= SATL_DONE;
        default: state_r <= SATL_IDLE;
      endcase
    end
  end

  // =======================================================
  // Memory
  always_ff @(posedge clk_i)
  begin
    if (rst_i || start_i) wr_addr_o <= ADDR_RST;
    else if (wr) wr_addr_o <= wr_addr_o + 8'h01;
  end

  always_ff @(posedge clk_i)
  begin
    if (wr) mem[wr_addr_o] <= data_i;
    rd_data_o <= mem[rd_addr_i];
  end
endmodule : satl_acq
`default_nettype wire

// ---- satl_sut_model.sv ----
/*
 Model of the system-under-test bus and the aux probe channels.
 Assumes the bench chooses the levels; state edge every 4 clocks.
*/
`default_nettype none
module satl_sut_model
  import satl_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic [MAIN_W-1:0] main_i,
  input  wire logic [AUX_W-1:0]  aux_i,
  output logic                   st_en_o = 1'b0,
  output logic      [MAIN_W-1:0] main_o = '0,
  output logic      [AUX_W-1:0]  aux_o = '0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_r = 2'h0;
  // ==========
  // Bus levels
  // Levels change one clock after the bench asks, as on a real bus
  always @(posedge clk_i)
  begin
    div_r   <= div_r + 2'h1;
    st_en_o <= (div_r == 2'h3);
    main_o  <= main_i;
    aux_o   <= aux_i;
  end
endmodule : satl_sut_model
`default_nettype wire

// ---- satl_tb.sv ----
/*
 Self-checking bench for the synchronous auxiliary trigger link.
 Assumes satl_pkg, satl_link and satl_sut_model are compiled first.
*/
`default_nettype none
module testbench
  import satl_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     clk = 1'b0, rst = 1'b1, arm = 1'b0, sync = 1'b1, qual = 1'b1;
  logic                     ext = 1'b0, cmd_m = 1'b0, cmd_a = 1'b0, st_en;
  logic [NUM_WR*MAIN_W-1:0] wr_val = '0, wr_care = '0;
  logic [NUM_WR*2-1:0]      wr_ext = 8'haa, wr_link = 8'haa;
  logic [NUM_WR-1:0]        used_m = 4'h0, used_a = 4'h0, wr_ev;
  logic [AUX_W-1:0]         aux_val = 8'h00, aux_care = 8'hcc, aux_set = 8'h40, aux_d, aux_rd;
  logic [MAIN_W-1:0]        main_set = 16'h5a3c, main_d, main_rd;
  logic [CNT_W-1:0]         dly_m = 16'h0000, dly_a = 16'h0002;
  logic [ADDR_W-1:0]        rd_m = 8'h00, rd_a = 8'h00, cnt_m, cnt_a;
  logic                     aux_wr, trig_m, trig_a, done_m, done_a;
  int                       errors = 0, cmp_count = 0, n_tm = 0, n_ta = 0;

  initial forever #12.5 clk = ~clk;
  // Counting pulses exposes double or missing triggers
  always @(posedge clk)
  begin
    if (trig_m === 1'b1)
      n_tm <= n_tm + 1;
    if (trig_a === 1'b1)
      n_ta <= n_ta + 1;
  end

  satl_sut_model u_sut (.clk_i(clk), .main_i(main_set), .aux_i(aux_set), .st_en_o(st_en),
    .main_o(main_d), .aux_o(aux_d));
  satl_link u_dut (
    .CLK_I(clk), .RST_I(rst), .STATE_EN_I(st_en), .ARM_I(arm), .SYNC_MODE_I(sync),
    .QUALIFY_I(qual), .MAIN_DATA_I(main_d), .AUX_DATA_I(aux_d),
    .EXTERNAL_TRIGGER_INPUT_I(ext), .WR_VAL_I(wr_val), .WR_CARE_I(wr_care),
    .WR_EXT_I(wr_ext), .WR_LINK_I(wr_link), .WR_USED_MAIN_I(used_m), .WR_USED_AUX_I(used_a),
    .AUX_VAL_I(aux_val), .AUX_CARE_I(aux_care), .CMD_TRIG_MAIN_I(cmd_m), .CMD_TRIG_AUX_I(cmd_a),
    .MAIN_DELAY_I(dly_m), .AUX_DELAY_I(dly_a), .MAIN_RD_ADDR_I(rd_m), .AUX_RD_ADDR_I(rd_a),
    .MAIN_RD_DATA_O(main_rd), .AUX_RD_DATA_O(aux_rd), .WR_EVENT_O(wr_ev), .AUX_WR_O(aux_wr),
    .MAIN_TRIG_O(trig_m), .AUX_TRIG_O(trig_a), .MAIN_DONE_O(done_m), .AUX_DONE_O(done_a),
    .MAIN_COUNT_O(cnt_m), .AUX_COUNT_O(cnt_a));

  // ==========
  // Tasks
  task automatic wrap_up();
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Returns at a clock edge where the design sampled a state edge
  task automatic edges(input int n);
    int k;
    repeat (n)
    begin
      k = 0;
      do
      begin
        @(posedge clk);
        k++;
      end
      while (st_en !== 1'b1 && k < 8);
      if (k == 8)
      begin
        errors++;
        wrap_up();
      end
    end
  endtask : edges

  // Two clocks cover the output register and the read latency
  task automatic look();
    repeat (2) @(posedge clk);
    #1;
  endtask : look

  task automatic wait_hi(ref logic f, input int lim);
    int k;
    for (k = 0; k < lim && f !== 1'b1; k++)
      @(posedge clk) #1;
    if (f !== 1'b1)
    begin
      errors++;
      $display("mismatch flag_wait expected 1 seen %b", f);
      wrap_up();
    end
  endtask : wait_hi

  // ==========
  // Sequence
  initial
  begin
    bit ok;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    look();
    chk("idle_outputs", 32'h0, {trig_m, trig_a, done_m, done_a, cnt_m, cnt_a});
    for (int k = 0; k < 3; k++)
      for (int m = 0; m < 2; m++)
      begin
        wr_link <= {4{k[1:0]}};
        aux_set <= (m == 1) ? 8'h33 : 8'h40;
        edges(2);
        look();
        ok = (k == 2) || ((k == 1) == (m == 1));
        chk("wr_event", {4{ok}}, wr_ev);
        chk("aux_event", m, aux_wr);
      end
    wr_link <= 8'h55;
    aux_set <= 8'h40;
    aux_val <= 8'h40;
    edges(2);
    look();
    chk("shared_pattern", 4'hf, wr_ev);
    aux_val <= 8'h00;
    edges(2);
    @(posedge clk) aux_set <= 8'h33;
    @(posedge clk) aux_set <= 8'h40;
    edges(1);
    look();
    chk("stretched_event", 1, aux_wr);
    edges(1);
    look();
    chk("event_false", 1'b0, aux_wr);
    arm <= 1'b1;
    qual <= 1'b0;
    cmd_a <= 1'b1;
    aux_set <= 8'ha5;
    @(posedge clk) arm <= 1'b0;
    edges(3);
    look();
    chk("aux_count", 8'h00, cnt_a);
    qual <= 1'b1;
    edges(2);
    look();
    chk("aux_count", 8'h02, cnt_a);
    sync <= 1'b0;
    qual <= 1'b0;
    edges(2);
    look();
    chk("aux_count", 8'h04, cnt_a);
    chk("aux_mem", 8'ha5, aux_rd);
    chk("aux_trig_count", 0, n_ta);
    sync <= 1'b1;
    qual <= 1'b1;
    wr_link <= 8'haa;
    used_a <= 4'h1;
    wait_hi(trig_a, 16);
    @(posedge clk) #1;
    chk("aux_trig_width", 1'b0, trig_a);
    edges(1);
    look();
    chk("aux_done_early", 1'b0, done_a);
    wait_hi(done_a, 24);
    chk("trig_counts", {16'h0, 16'h1}, {n_tm[15:0], n_ta[15:0]});
    chk("main_done", 1'b0, done_m);
    arm <= 1'b1;
    used_a <= 4'h0;
    cmd_a <= 1'b0;
    cmd_m <= 1'b1;
    used_m <= 4'h2;
    wr_link <= 8'h04;
    wr_val <= {32'h0, 16'h5a3c, 16'h0};
    wr_care <= {32'h0, 16'hff00, 16'h0};
    @(posedge clk) arm <= 1'b0;
    edges(2);
    look();
    chk("rearm_state", {16'h0, 16'h0}, {n_tm[15:0], 15'h0, done_a});
    aux_set <= 8'h33;
    wait_hi(trig_m, 16);
    wait_hi(done_m, 24);
    look();
    chk("trig_counts", {16'h1, 16'h1}, {n_tm[15:0], n_ta[15:0]});
    chk("main_mem", 16'h5a3c, main_rd);
    chk("main_count", 8'h04, cnt_m);
    aux_care <= 8'h00;
    aux_set  <= 8'ha5;
    edges(2);
    look();
    chk("aux_dont_care", 1'b1, aux_wr);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
